// >>> verilog/ecrb_consts.vh
// constants for the ethernet control register bank
`ifndef ECRB_CONSTS_VH
`define ECRB_CONSTS_VH

// register indices inside a bank (5-bit address)
`define ECRB_ADR_COLLISION_WINDOW     5'h0A
`define ECRB_ADR_MFL_L      5'h0B
`define ECRB_ADR_MFL_H      5'h0C
`define ECRB_ADR_MCMD       5'h0D
`define ECRB_ADR_MREGSEL    5'h0E
`define ECRB_ADR_MWR_L      5'h0F
`define ECRB_ADR_MWR_H      5'h10
`define ECRB_ADR_MRD_L      5'h11
`define ECRB_ADR_MRD_H      5'h12
`define ECRB_ADR_SA5        5'h13
`define ECRB_ADR_SA6        5'h14
`define ECRB_ADR_SA3        5'h15
`define ECRB_ADR_SA4        5'h16
`define ECRB_ADR_SA1        5'h17
`define ECRB_ADR_SA2        5'h18
`define ECRB_ADR_BSEED      5'h08
`define ECRB_ADR_BCON       5'h07
`define ECRB_ADR_BSUM_L     5'h09
`define ECRB_ADR_BSUM_H     5'h06
`define ECRB_ADR_MSTAT      5'h05
`define ECRB_ADR_REVID      5'h04
`define ECRB_ADR_COCON      5'h03
`define ECRB_ADR_FLOCON     5'h02
`define ECRB_ADR_PAUS_L     5'h01
`define ECRB_ADR_PAUS_H     5'h00
// common to all banks
`define ECRB_ADR_MAIN1      5'h1F

// bank numbers
`define ECRB_BANK_MAC       2'h2
`define ECRB_BANK_MISC      2'h3

// main control bit positions
`define ECRB_B_TXRESET      7
`define ECRB_B_RXRESET      6
`define ECRB_B_DMABUSY      5
`define ECRB_B_CSUM         4
`define ECRB_B_TXREQ        3
`define ECRB_B_RX_ENABLE         2

// reset values
`define ECRB_RST_COLLISION_WINDOW     8'h37
`define ECRB_RST_MFL_H      8'h06
`define ECRB_RST_COCON      3'h4
`define ECRB_RST_PAUS_H     8'h10
`define ECRB_RST_ZERO       8'h00

// field masks
`define ECRB_MSK_COLLISION_WINDOW     8'h3F
`define ECRB_MSK_MCMD       8'h03
`define ECRB_MSK_MREGSEL    8'h1F
`define ECRB_MSK_FLOCON     8'h03

`endif

// >>> verilog/ecrb_reg_bank.v
// main control register bank of the ethernet controller
//
// Contract
// - while tx_logic_reset is 1 the whole transmit path is held in reset.
// - while rx_logic_reset is 1 the receive path is held in reset.
// - the host sets dma_start_busy to start the DMA and it reads 1 until the DMA is idle.
// - dma_checksum_select picks checksum (1) or copy (0) for a started DMA operation.
// - tx_request asks for a send and reads 1 while transmit is busy, 0 when idle.
// - rx_enable gates whether filtered packets are written into the receive buffer.
// - the two bank select bits steer register accesses to bank 0 to 3 by their value.
// - clock_ready_flag clears on power-on reset or when clk_stable drops, and survives other resets.
// - revision_id is read-only and host writes leave it unchanged.
// - clock_out_control loads 100 on power-on reset and keeps its value on other resets.
// - unimplemented bits always read as 0.
`timescale 1ns/100ps
`default_nettype none
`include "ecrb_consts.vh"

module ecrb_reg_bank #(
  parameter [4:0] REVISION = 5'h06  // arbitrary value
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       soft_rst,
  input  wire       clk_stable,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [4:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       dma_done,
  input  wire       tx_done,
  input  wire       mgmt_busy,
  input  wire       mgmt_scan,
  input  wire       mgmt_mgmt_data_not_valid,
  input  wire       mgmt_rd_valid,
  input  wire [15:0] mgmt_rd_data,
  input  wire [15:0] selftest_sum,
  input  wire       selftest_sum_valid,
  output wire       tx_path_reset,
  output wire       rx_path_reset,
  output wire       dma_go,
  output wire       dma_checksum_mode,
  output wire       tx_go,
  output wire       rx_write_enable,
  output wire [1:0] bank_sel,
  output wire       clock_ready_flag,
  output wire [2:0] clock_out_sel,
  output wire [15:0] max_frame_len,
  output wire [5:0] collision_window,
  output wire [47:0] station_addr,
  output wire [15:0] pause_timer_value,
  output wire [1:0] flow_ctrl_sel,
  output wire       mgmt_scan_cmd,
  output wire       mgmt_read_cmd,
  output wire [4:0] mgmt_phy_reg,
  output wire [15:0] mgmt_write_data
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pin-level status

  reg  [1:0] clk_stable_s_ff;
  reg  [1:0] mgmt_busy_s_ff;
  reg  [1:0] mgmt_scan_s_ff;
  reg  [1:0] mgmt_mgmt_data_not_valid_s_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_stable_s_ff  <= 2'h0;
      mgmt_busy_s_ff   <= 2'h0;
      mgmt_scan_s_ff   <= 2'h0;
      mgmt_mgmt_data_not_valid_s_ff <= 2'h0;
    end else begin
      clk_stable_s_ff  <= {clk_stable_s_ff[0], clk_stable};
      mgmt_busy_s_ff   <= {mgmt_busy_s_ff[0], mgmt_busy};
      mgmt_scan_s_ff   <= {mgmt_scan_s_ff[0], mgmt_scan};
      mgmt_mgmt_data_not_valid_s_ff <= {mgmt_mgmt_data_not_valid_s_ff[0], mgmt_mgmt_data_not_valid};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on-only state: rst is the power-on reset, soft_rst any other

  reg        clk_ready_ff;
  reg  [2:0] cocon_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_ready_ff <= 1'b0;
    end else begin
      clk_ready_ff <= clk_stable_s_ff[1];
    end
  end

  wire wr_misc;
  wire wr_mac;
  wire wr_main;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cocon_ff <= `ECRB_RST_COCON;
    end else if (wr_misc && reg_addr == `ECRB_ADR_COCON) begin
      cocon_ff <= reg_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  reg  [7:0] main1_ff;

  assign wr_main = reg_wr && reg_addr == `ECRB_ADR_MAIN1;
  assign wr_mac  = reg_wr && main1_ff[1:0] == `ECRB_BANK_MAC;
  assign wr_misc = reg_wr && main1_ff[1:0] == `ECRB_BANK_MISC;

  ////////////////////////////////////////////////////////////////////////
  // main control register

  reg  [7:0] nxt_main1;

  always @* begin
    nxt_main1 = main1_ff;
    if (wr_main) begin
      nxt_main1 = reg_wdata;
      if (main1_ff[`ECRB_B_DMABUSY])
        nxt_main1[`ECRB_B_DMABUSY] = 1'b1;
      if (main1_ff[`ECRB_B_TXREQ])
        nxt_main1[`ECRB_B_TXREQ] = 1'b1;
    end
    if (dma_done)
      nxt_main1[`ECRB_B_DMABUSY] = 1'b0;
    if (tx_done || main1_ff[`ECRB_B_TXRESET])
      nxt_main1[`ECRB_B_TXREQ] = 1'b0;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      main1_ff <= 8'h00;
    end else if (soft_rst) begin
      main1_ff <= 8'h00;
    end else begin
      main1_ff <= nxt_main1;
    end
  end

  assign tx_path_reset     = main1_ff[`ECRB_B_TXRESET];
  assign rx_path_reset     = main1_ff[`ECRB_B_RXRESET];
  assign dma_go            = main1_ff[`ECRB_B_DMABUSY];
  assign dma_checksum_mode = main1_ff[`ECRB_B_CSUM];
  assign tx_go             = main1_ff[`ECRB_B_TXREQ] & ~main1_ff[`ECRB_B_TXRESET];
  assign rx_write_enable   = main1_ff[`ECRB_B_RX_ENABLE] & ~main1_ff[`ECRB_B_RXRESET];
  assign bank_sel          = main1_ff[1:0];
  assign clock_ready_flag  = clk_ready_ff;
  assign clock_out_sel     = cocon_ff;

  ////////////////////////////////////////////////////////////////////////
  // plain read/write registers: table of index, reset, mask, bank

  localparam NREG = 18;

  // one function per field: a packed table word loses fields silently when a width slips
  function [1:0] ecrb_bank;
    input integer i;
    begin
      case (i)
        0:       ecrb_bank = `ECRB_BANK_MAC;
        1:       ecrb_bank = `ECRB_BANK_MAC;
        2:       ecrb_bank = `ECRB_BANK_MAC;
        3:       ecrb_bank = `ECRB_BANK_MAC;
        4:       ecrb_bank = `ECRB_BANK_MAC;
        5:       ecrb_bank = `ECRB_BANK_MAC;
        6:       ecrb_bank = `ECRB_BANK_MAC;
        7:       ecrb_bank = `ECRB_BANK_MISC;
        8:       ecrb_bank = `ECRB_BANK_MISC;
        9:       ecrb_bank = `ECRB_BANK_MISC;
        10:      ecrb_bank = `ECRB_BANK_MISC;
        11:      ecrb_bank = `ECRB_BANK_MISC;
        12:      ecrb_bank = `ECRB_BANK_MISC;
        13:      ecrb_bank = `ECRB_BANK_MISC;
        14:      ecrb_bank = `ECRB_BANK_MISC;
        15:      ecrb_bank = `ECRB_BANK_MISC;
        16:      ecrb_bank = `ECRB_BANK_MISC;
        default: ecrb_bank = `ECRB_BANK_MISC;
      endcase
    end
  endfunction

  function [4:0] ecrb_index;
    input integer i;
    begin
      case (i)
        0:       ecrb_index = `ECRB_ADR_COLLISION_WINDOW;
        1:       ecrb_index = `ECRB_ADR_MFL_L;
        2:       ecrb_index = `ECRB_ADR_MFL_H;
        3:       ecrb_index = `ECRB_ADR_MCMD;
        4:       ecrb_index = `ECRB_ADR_MREGSEL;
        5:       ecrb_index = `ECRB_ADR_MWR_L;
        6:       ecrb_index = `ECRB_ADR_MWR_H;
        7:       ecrb_index = `ECRB_ADR_SA5;
        8:       ecrb_index = `ECRB_ADR_SA6;
        9:       ecrb_index = `ECRB_ADR_SA3;
        10:      ecrb_index = `ECRB_ADR_SA4;
        11:      ecrb_index = `ECRB_ADR_SA1;
        12:      ecrb_index = `ECRB_ADR_SA2;
        13:      ecrb_index = `ECRB_ADR_BSEED;
        14:      ecrb_index = `ECRB_ADR_BCON;
        15:      ecrb_index = `ECRB_ADR_FLOCON;
        16:      ecrb_index = `ECRB_ADR_PAUS_L;
        default: ecrb_index = `ECRB_ADR_PAUS_H;
      endcase
    end
  endfunction

  function [7:0] ecrb_init;
    input integer i;
    begin
      case (i)
        0:       ecrb_init = `ECRB_RST_COLLISION_WINDOW;
        1:       ecrb_init = `ECRB_RST_ZERO;
        2:       ecrb_init = `ECRB_RST_MFL_H;
        3:       ecrb_init = `ECRB_RST_ZERO;
        4:       ecrb_init = `ECRB_RST_ZERO;
        5:       ecrb_init = `ECRB_RST_ZERO;
        6:       ecrb_init = `ECRB_RST_ZERO;
        7:       ecrb_init = `ECRB_RST_ZERO;
        8:       ecrb_init = `ECRB_RST_ZERO;
        9:       ecrb_init = `ECRB_RST_ZERO;
        10:      ecrb_init = `ECRB_RST_ZERO;
        11:      ecrb_init = `ECRB_RST_ZERO;
        12:      ecrb_init = `ECRB_RST_ZERO;
        13:      ecrb_init = `ECRB_RST_ZERO;
        14:      ecrb_init = `ECRB_RST_ZERO;
        15:      ecrb_init = `ECRB_RST_ZERO;
        16:      ecrb_init = `ECRB_RST_ZERO;
        default: ecrb_init = `ECRB_RST_PAUS_H;
      endcase
    end
  endfunction

  function [7:0] ecrb_mask;
    input integer i;
    begin
      case (i)
        0:       ecrb_mask = `ECRB_MSK_COLLISION_WINDOW;
        1:       ecrb_mask = 8'hFF;
        2:       ecrb_mask = 8'hFF;
        3:       ecrb_mask = `ECRB_MSK_MCMD;
        4:       ecrb_mask = `ECRB_MSK_MREGSEL;
        5:       ecrb_mask = 8'hFF;
        6:       ecrb_mask = 8'hFF;
        7:       ecrb_mask = 8'hFF;
        8:       ecrb_mask = 8'hFF;
        9:       ecrb_mask = 8'hFF;
        10:      ecrb_mask = 8'hFF;
        11:      ecrb_mask = 8'hFF;
        12:      ecrb_mask = 8'hFF;
        13:      ecrb_mask = 8'hFF;
        14:      ecrb_mask = 8'hFF;
        15:      ecrb_mask = `ECRB_MSK_FLOCON;
        16:      ecrb_mask = 8'hFF;
        default: ecrb_mask = 8'hFF;
      endcase
    end
  endfunction

  wire [7:0] rw_q [0:NREG-1];
  wire [NREG-1:0] rw_hit;

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_rw
      localparam [1:0] ENT_BANK = ecrb_bank(g);
      localparam [4:0] ENT_IDX  = ecrb_index(g);
      localparam [7:0] ENT_INIT = ecrb_init(g);
      localparam [7:0] ENT_MASK = ecrb_mask(g);
      reg [7:0] val_ff;
      assign rw_hit[g] = main1_ff[1:0] == ENT_BANK && reg_addr == ENT_IDX;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          val_ff <= ENT_INIT;
        end else if (soft_rst) begin
          val_ff <= ENT_INIT;
        end else if (reg_wr && rw_hit[g]) begin
          val_ff <= reg_wdata & ENT_MASK;
        end
      end
      assign rw_q[g] = val_ff;
    end
  endgenerate

  assign collision_window  = rw_q[0][5:0];
  assign max_frame_len     = {rw_q[2], rw_q[1]};
  assign mgmt_read_cmd     = rw_q[3][0];
  assign mgmt_scan_cmd     = rw_q[3][1];
  assign mgmt_phy_reg      = rw_q[4][4:0];
  assign mgmt_write_data   = {rw_q[6], rw_q[5]};
  assign station_addr      = {rw_q[11], rw_q[12], rw_q[9], rw_q[10], rw_q[7], rw_q[8]};
  assign flow_ctrl_sel     = rw_q[15][1:0];
  assign pause_timer_value = {rw_q[17], rw_q[16]};

  ////////////////////////////////////////////////////////////////////////
  // hardware-loaded result registers

  reg [15:0] mrd_ff;
  reg [15:0] bsum_ff;

  // hardware load wins over a host write in the same cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mrd_ff  <= 16'h0000;
      bsum_ff <= 16'h0000;
    end else begin
      if (mgmt_rd_valid)
        mrd_ff <= mgmt_rd_data;
      else if (wr_mac && reg_addr == `ECRB_ADR_MRD_L)
        mrd_ff[7:0] <= reg_wdata;
      else if (wr_mac && reg_addr == `ECRB_ADR_MRD_H)
        mrd_ff[15:8] <= reg_wdata;
      if (selftest_sum_valid)
        bsum_ff <= selftest_sum;
      else if (wr_misc && reg_addr == `ECRB_ADR_BSUM_L)
        bsum_ff[7:0] <= reg_wdata;
      else if (wr_misc && reg_addr == `ECRB_ADR_BSUM_H)
        bsum_ff[15:8] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered

  reg [7:0] nxt_rdata;
  integer k;

  always @* begin
    nxt_rdata = 8'h00;
    for (k = 0; k < NREG; k = k + 1)
      if (rw_hit[k])
        nxt_rdata = rw_q[k];
    if (reg_addr == `ECRB_ADR_MAIN1)
      nxt_rdata = main1_ff;
    else if (main1_ff[1:0] == `ECRB_BANK_MAC) begin
      if (reg_addr == `ECRB_ADR_MRD_L)
        nxt_rdata = mrd_ff[7:0];
      else if (reg_addr == `ECRB_ADR_MRD_H)
        nxt_rdata = mrd_ff[15:8];
    end else if (main1_ff[1:0] == `ECRB_BANK_MISC) begin
      case (reg_addr)
        `ECRB_ADR_BSUM_L: nxt_rdata = bsum_ff[7:0];
        `ECRB_ADR_BSUM_H: nxt_rdata = bsum_ff[15:8];
        `ECRB_ADR_MSTAT:  nxt_rdata = {5'h00, mgmt_mgmt_data_not_valid_s_ff[1], mgmt_scan_s_ff[1], mgmt_busy_s_ff[1]};
        `ECRB_ADR_REVID:  nxt_rdata = {3'h0, REVISION};
        `ECRB_ADR_COCON:  nxt_rdata = {5'h00, cocon_ff};
        `ECRB_ADR_FLOCON: nxt_rdata = {5'h00, ~rw_q[15][1] & 1'b0, rw_q[15][1:0]};
        default:          nxt_rdata = nxt_rdata;
      endcase
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end

endmodule // ecrb_reg_bank
`default_nettype wire

// >>> testbench/ecrb_reg_bank_sva.sv
// assertion checker for the ethernet control register bank
`timescale 1ns/100ps
`default_nettype none
`include "ecrb_consts.vh"
module ecrb_reg_bank_sva (
  input wire       ref_clk,
  input wire       rst,
  input wire       soft_rst,
  input wire       reg_wr,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       dma_done,
  input wire       tx_done,
  input wire       tx_path_reset,
  input wire       rx_path_reset,
  input wire       dma_go,
  input wire       dma_checksum_mode,
  input wire       tx_go,
  input wire       rx_write_enable,
  input wire [1:0] bank_sel,
  input wire [2:0] clock_out_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // soft reset wins over a host write, so leave it out
  sequence s_main_wr;
    reg_wr && reg_addr == `ECRB_ADR_MAIN1 && !soft_rst;
  endsequence
  sequence s_dma_run;
    dma_go && !dma_done && !soft_rst;
  endsequence
  ////////////////////////////////////////////////////////////
  tx_reset_a: assert property (s_main_wr ##0 reg_wdata[7] |=> tx_path_reset && !tx_go)
    else $error("transmit path not held in reset");
  rx_reset_a: assert property (s_main_wr ##0 reg_wdata[6] |=> rx_path_reset && !rx_write_enable)
    else $error("receive path not held in reset");
  dma_start_a: assert property (s_main_wr ##0 (reg_wdata[5] && !dma_done) |=> dma_go)
    else $error("dma not started");
  dma_hold_a: assert property (s_dma_run |=> dma_go)
    else $error("dma busy dropped early");
  dma_clear_a: assert property (dma_done |=> !dma_go)
    else $error("dma busy not cleared on done");
  csum_sel_a: assert property (s_main_wr |=> dma_checksum_mode == $past(reg_wdata[4]))
    else $error("dma mode differs from written bit");
  tx_done_a: assert property (tx_done |=> !tx_go)
    else $error("transmit request not cleared on done");
  rx_enable_a: assert property (s_main_wr ##0 !reg_wdata[6] |=> rx_write_enable == $past(reg_wdata[2]))
    else $error("receive enable differs from written bit");
  bank_sel_a: assert property (s_main_wr |=> bank_sel == $past(reg_wdata[1:0]))
    else $error("bank select differs from written value");
  cocon_keep_a: assert property (soft_rst && !reg_wr |=> $stable(clock_out_sel))
    else $error("clock out select changed on soft reset");
endmodule // ecrb_reg_bank_sva

bind ecrb_reg_bank ecrb_reg_bank_sva chk (.ref_clk, .rst, .soft_rst, .reg_wr, .reg_addr, .reg_wdata, .dma_done,
  .tx_done, .tx_path_reset, .rx_path_reset, .dma_go, .dma_checksum_mode, .tx_go, .rx_write_enable, .bank_sel,
  .clock_out_sel);
`default_nettype wire

// >>> testbench/ecrb_host_model.sv
// host register master model for the control register bank
`timescale 1ns/100ps
`default_nettype none
module ecrb_host_model (
  input  wire        ref_clk,
  input  wire  [7:0] reg_rdata,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  // whole byte, reserved bits as passed in d, no read-back
  task wr(input [4:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // released lines carry junk, never the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task rd(input [4:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask
endmodule // ecrb_host_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam [4:0] REV = 5'h0B; // arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic        clk_stable = 1'b0;
  logic        dma_done = 1'b0;
  logic        tx_done = 1'b0;
  logic        mgmt_rd_valid = 1'b0;
  logic [15:0] mgmt_rd_data = 16'h0000;
  logic        mgmt_busy = 1'b0, mgmt_scan = 1'b0, mgmt_mgmt_data_not_valid = 1'b0;
  wire         mgmt_scan_cmd, mgmt_read_cmd;
  wire [15:0]  max_frame_len, pause_timer_value, mgmt_write_data;
  wire [4:0]   mgmt_phy_reg;
  wire [1:0]   flow_ctrl_sel;
  wire         reg_wr, reg_rd, tx_path_reset, rx_path_reset, dma_go, dma_checksum_mode;
  wire         tx_go, rx_write_enable, clock_ready_flag;
  wire [4:0]   reg_addr;
  wire [7:0]   reg_wdata, reg_rdata;
  wire [1:0]   bank_sel;
  wire [2:0]   clock_out_sel;
  wire [5:0]   collision_window;
  wire [47:0]  station_addr;
  int          failures = 0, comparisons = 0, cycles = 0;

  // one load strobe feeds both result registers, so one stimulus covers both
  ecrb_reg_bank #(.REVISION(REV)) dut (
    .ref_clk, .rst, .soft_rst, .clk_stable, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .dma_done, .tx_done, .mgmt_busy, .mgmt_scan, .mgmt_mgmt_data_not_valid, .mgmt_rd_valid, .mgmt_rd_data,
    .selftest_sum(mgmt_rd_data), .selftest_sum_valid(mgmt_rd_valid), .tx_path_reset, .rx_path_reset, .dma_go,
    .dma_checksum_mode, .tx_go, .rx_write_enable, .bank_sel, .clock_ready_flag, .clock_out_sel,
    .max_frame_len, .collision_window, .station_addr, .pause_timer_value, .flow_ctrl_sel,
    .mgmt_scan_cmd, .mgmt_read_cmd, .mgmt_phy_reg, .mgmt_write_data);
  ecrb_host_model host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task chk(input [47:0] g, input [47:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wrc(input [4:0] a, input [7:0] d);
    host.wr(a, d);
    cyc(1);
  endtask
  task rdc(input [4:0] a, input [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task pulse(input bit dma);
    @(posedge ref_clk);
    dma_done <= dma;
    tx_done <= !dma;
    @(posedge ref_clk);
    dma_done <= 1'b0;
    tx_done <= 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
    rdc(5'h1F, 8'h00);
    wrc(5'h1F, 8'h02);
    rdc(5'h0A, 8'h37);
    rdc(5'h0C, 8'h06);
    wrc(5'h1F, 8'h03);
    rdc(5'h03, 8'h04);
    rdc(5'h00, 8'h10);
    wrc(5'h04, 8'hFF);
    rdc(5'h04, {3'h0, REV});
    wrc(5'h02, 8'hFF);
    rdc(5'h02, 8'h03);
    wrc(5'h19, 8'hFF);
    rdc(5'h19, 8'h00);
  endtask
  task t_misc;
    wrc(5'h1F, 8'h02);
    wrc(5'h0B, 8'hEE);
    wrc(5'h0C, 8'h05);
    chk(max_frame_len, 16'h05EE);
    wrc(5'h0D, 8'hFF);
    rdc(5'h0D, 8'h03);
    chk({mgmt_scan_cmd, mgmt_read_cmd}, 2'h3);
    wrc(5'h0E, 8'hFF);
    chk(mgmt_phy_reg, 5'h1F);
    wrc(5'h0F, 8'h5A);
    wrc(5'h10, 8'hC3);
    chk(mgmt_write_data, 16'hC35A);
    wrc(5'h1F, 8'h03);
    wrc(5'h01, 8'h22);
    chk(pause_timer_value, 16'h1022);
    chk(flow_ctrl_sel, 2'h3);
    @(posedge ref_clk);
    {mgmt_mgmt_data_not_valid, mgmt_scan, mgmt_busy} <= 3'h5;
    cyc(2);
    rdc(5'h05, 8'h05);
    wrc(5'h05, 8'hFF);
    rdc(5'h05, 8'h05);
  endtask
  task t_bank;
    for (int b = 0; b < 4; b++) begin
      wrc(5'h1F, 8'(b));
      chk(bank_sel, b[1:0]);
    end
    wrc(5'h17, 8'hA5);
    chk(station_addr[47:40], 8'hA5);
    wrc(5'h1F, 8'h02);
    rdc(5'h17, 8'h00);
    wrc(5'h0A, 8'hFF);
    chk(collision_window, 6'h3F);
  endtask
  task t_dma;
    wrc(5'h1F, 8'h30);
    chk({dma_go, dma_checksum_mode}, 2'h3);
    // zero on the busy bit must not stop the engine
    wrc(5'h1F, 8'h00);
    rdc(5'h1F, 8'h20);
    chk(dma_checksum_mode, 1'b0);
    pulse(1'b1);
    chk(dma_go, 1'b0);
  endtask
  task t_tx;
    wrc(5'h1F, 8'h0C);
    chk({tx_go, rx_write_enable}, 2'h3);
    wrc(5'h1F, 8'hCC);
    chk({tx_path_reset, rx_path_reset, tx_go, rx_write_enable}, 4'hC);
    wrc(5'h1F, 8'h04);
    chk({tx_go, rx_write_enable}, 2'h1);
    wrc(5'h1F, 8'h08);
    pulse(1'b0);
    rdc(5'h1F, 8'h00);
  endtask
  task t_mgmt;
    @(posedge ref_clk);
    mgmt_rd_valid <= 1'b1;
    mgmt_rd_data <= 16'h1234;
    @(posedge ref_clk);
    mgmt_rd_valid <= 1'b0;
    wrc(5'h1F, 8'h02);
    rdc(5'h11, 8'h34);
    rdc(5'h12, 8'h12);
    wrc(5'h1F, 8'h03);
    rdc(5'h09, 8'h34);
    rdc(5'h06, 8'h12);
  endtask
  task t_resets;
    wrc(5'h1F, 8'h03);
    wrc(5'h03, 8'h02);
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    cyc(1);
    chk({clock_ready_flag, clock_out_sel}, 4'hA);
    rdc(5'h1F, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    cyc(2);
    chk({clock_ready_flag, clock_out_sel}, 4'h4);
    @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // whole run is under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    clk_stable <= 1'b1;
    t_reset;
    t_misc;
    t_bank;
    t_dma;
    t_tx;
    t_mgmt;
    t_resets;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
